// file: hw/rcs_defs.svh
// constants of the reset cause and release timing block
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH
// apb word offsets
`define RCS_OFF_STATUS 12'h000
`define RCS_OFF_CLKSEL 12'h004
`define RCS_OFF_TIMING 12'h008
// status bit positions
`define RCS_B_TRAP 15
`define RCS_B_BADOP 14
`define RCS_B_VREG 8
`define RCS_B_PIN 7
`define RCS_B_SWR 6
`define RCS_B_SWDT 5
`define RCS_B_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_B_SLEEP 3
`define RCS_B_IDLE 2
`define RCS_B_BOR 1
`define RCS_B_POR 0
// implemented bits of the status word
`define RCS_STATUS_MASK 16'hC1FF
`define RCS_STATUS_POR_VAL 16'h0003
// times in nanoseconds, clock period in ns
`define RCS_CLK_NS 5
`define RCS_T_POR_NS 10000
`define RCS_T_STARTUP_NS 20000
`define RCS_T_POWER_UP_TIMER_NS 64000000
`define RCS_T_RST_NS 20000
`define RCS_T_LOCK_NS 20000
`define RCS_T_CLOCK_FAIL_MONITOR_NS 100000
`define RCS_OST_COUNT 1024
// oscillator select codes
`define RCS_OSC_PRI 3'h2
`define RCS_OSC_PRIPLL 3'h3
`define RCS_OSC_SEC 3'h4
`define RCS_OSC_FRCPLL 3'h1
`endif

// file: hw/rcs_pkg.sv
// types of the reset cause and release timing block
package rcs_pkg;
    // reset source pulses, one bit per cause
    typedef struct packed {
        logic por;
        logic bor;
        logic pin;
        logic instruction_reset_flag;
        logic wdt;
        logic trap;
        logic badop;
    } rcs_src_type;
    // sequencer states
    typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_WAKE} rcs_state_type;
endpackage : rcs_pkg

// file: hw/rcs_sync.sv
// three stage synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module rcs_sync (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic d_in,
    output logic q_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;
    // stage chain and agreement filter
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                q_ff <= s3_ff;
        end
    end
    assign q_out = q_ff;
endmodule : rcs_sync

// file: hw/rcs_timer.sv
// down counter that raises done when a loaded count runs out
`timescale 1ns/1ps
module rcs_timer #(
    parameter int W = 24
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    output logic done_out
);
    logic [W-1:0] cnt_ff;
    // count down; only a longer load restarts, so loads only extend
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            cnt_ff <= '0;
        else if (load_in && count_in > cnt_ff)
            cnt_ff <= count_in;
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end
    assign done_out = (cnt_ff == '0) && !load_in;
endmodule : rcs_timer

// file: hw/rcs_top.sv
// reset cause recording, clock source choice and system reset release timing
`timescale 1ns/1ps
`include "rcs_defs.svh"
// Notes on behaviour
// - any active source asserts system reset
// - power-on clears all flags except bits 1 and 0
// - bit 15 trap conflict, cleared por/bor/software
// - bit 14 bad opcode/pointer, cleared por/bor
// - bits 13 to 9 read zero
// - bit 8 keeps regulator on in sleep
// - bit 7 pin reset, cleared by por only
// - bit 6 reset instruction, cleared por/bor
// - bit 5 enables watchdog, fuse overrides
// - bit 4 watchdog timeout, cleared by powersave
// - bits 3,2 sleep and idle entry flags
// - bit 1 por/bor, bit 0 por
// - software sets/clears flags, never resets
// - switching on: por/bor use config field
// - switching off: always config field
// - power-on holds por+startup+internal time
// - startup 20us regulator on, else 64ms
// - startup applied on wake if regulator on
// - bor startup+internal, others internal only
// - crystal sources wait 1024 oscillator periods
// - pll lock waits run alongside hold
// - monitor waits 100us after release
// - no fetch until clock released
module rcs_top #(
    parameter int CNT_W = 24,
    parameter int POWER_UP_TIMER_CYC = `RCS_T_POWER_UP_TIMER_NS / `RCS_CLK_NS,
    parameter int CLOCK_FAIL_MONITOR_CYC = `RCS_T_CLOCK_FAIL_MONITOR_NS / `RCS_CLK_NS,
    parameter int STARTUP_CYC = `RCS_T_STARTUP_NS / `RCS_CLK_NS
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // reset sources and events, pulses in this clock domain; pin and pll lock are levels, the pin is synchronised
    input wire rcs_pkg::rcs_src_type src_in,
    input wire logic master_clear_pin_n_in,
    input wire logic sleep_enter_in,
    input wire logic idle_enter_in,
    input wire logic wake_in,
    input wire logic osc_tick_in,
    input wire logic pll_locked_in,
    // configuration straps
    input wire logic regulator_en_in,
    input wire logic clk_switch_en_in,
    input wire logic watchdog_fuse_enable_in,
    input wire logic [2:0] config_oscillator_select_in,
    input wire logic [2:0] current_oscillator_select_in,
    // outputs
    output logic system_reset_out,
    output logic clock_valid_out,
    output logic cpu_run_out,
    output logic monitor_active_out,
    output logic watchdog_en_out,
    output logic regulator_sleep_keepalive_out,
    output logic [2:0] reset_osc_select_out
);
    // ****************************************************************
    // cycle counts
    // ****************************************************************
    localparam int POR_CYC = (`RCS_T_POR_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS;
    localparam int RST_CYC = (`RCS_T_RST_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS;
    localparam int LOCK_CYC = (`RCS_T_LOCK_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS;

    // ****************************************************************
    // source decode
    // ****************************************************************
    logic pin_lvl; // synchronised pin level, high = asserted
    logic pin_q;
    logic pin_d_ff; // previous pin level
    rcs_sync u_pin (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .d_in(~master_clear_pin_n_in),
        .q_out(pin_q)
    );
    assign pin_lvl = pin_q;
    wire pin_evt = (pin_lvl & ~pin_d_ff) | src_in.pin;
    wire por_e = src_in.por;
    wire bor_e = src_in.bor | src_in.por;
    wire any_src = src_in.por | src_in.bor | pin_evt | src_in.instruction_reset_flag | src_in.wdt
        | src_in.trap | src_in.badop;
    wire pwr_sleep = sleep_enter_in | idle_enter_in;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire acc = psel_in & penable_in;
    wire wr = acc & pwrite_in;
    wire hit_st = paddr_in == `RCS_OFF_STATUS;
    wire hit_cs = paddr_in == `RCS_OFF_CLKSEL;
    wire hit_tm = paddr_in == `RCS_OFF_TIMING;
    wire hit = hit_st | hit_cs | hit_tm;
    wire wr_st = wr & hit_st;

    // ****************************************************************
    // status register
    // ****************************************************************
    logic [15:0] status_ff;
    logic [15:0] nxt_status;
    logic [15:0] hwset;
    logic [15:0] hwclr;
    // hardware set and clear masks per bit
    always_comb
    begin
        hwset = '0;
        hwclr = '0;
        hwset[`RCS_B_TRAP] = src_in.trap;
        hwset[`RCS_B_BADOP] = src_in.badop;
        hwset[`RCS_B_PIN] = pin_evt;
        hwset[`RCS_B_SWR] = src_in.instruction_reset_flag;
        hwset[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = src_in.wdt;
        hwset[`RCS_B_SLEEP] = sleep_enter_in;
        hwset[`RCS_B_IDLE] = idle_enter_in;
        hwset[`RCS_B_BOR] = bor_e;
        hwset[`RCS_B_POR] = por_e;
        if (bor_e)
        begin
            hwclr[`RCS_B_TRAP] = 1'b1;
            hwclr[`RCS_B_BADOP] = 1'b1;
            hwclr[`RCS_B_SWR] = 1'b1;
            hwclr[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
            hwclr[`RCS_B_SLEEP] = 1'b1;
            hwclr[`RCS_B_IDLE] = 1'b1;
        end
        if (por_e)
            hwclr = `RCS_STATUS_MASK;
        if (pwr_sleep)
            hwclr[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    end
    // software write first, then hardware clear, then hardware set wins
    always_comb
    begin
        nxt_status = status_ff;
        if (wr_st)
            nxt_status = pwdata_in[15:0];
        nxt_status = ((nxt_status & ~hwclr) | hwset) & `RCS_STATUS_MASK;
    end
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            status_ff <= `RCS_STATUS_POR_VAL;
        else
            status_ff <= nxt_status;
    end

    // ****************************************************************
    // clock source choice
    // ****************************************************************
    logic [2:0] osc_ff;
    wire cfg_src = !clk_switch_en_in || bor_e;
    wire [2:0] nxt_osc = cfg_src ? config_oscillator_select_in
        : current_oscillator_select_in;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            osc_ff <= '0;
        else if (any_src)
            osc_ff <= nxt_osc;
    end
    wire is_pll = osc_ff == `RCS_OSC_PRIPLL || osc_ff == `RCS_OSC_FRCPLL;
    wire is_xtal = osc_ff == `RCS_OSC_PRI || osc_ff == `RCS_OSC_SEC
        || osc_ff == `RCS_OSC_PRIPLL;

    // ****************************************************************
    // hold timer
    // ****************************************************************
    wire [CNT_W-1:0] su_cyc = regulator_en_in ? CNT_W'(STARTUP_CYC)
        : CNT_W'(POWER_UP_TIMER_CYC);
    logic [CNT_W-1:0] hold_cnt;
    // longest applicable hold wins when causes coincide
    always_comb
    begin
        hold_cnt = CNT_W'(RST_CYC);
        if (src_in.bor)
            hold_cnt = su_cyc + CNT_W'(RST_CYC);
        if (por_e)
            hold_cnt = CNT_W'(POR_CYC) + su_cyc + CNT_W'(RST_CYC);
    end
    logic hold_done;
    rcs_timer #(.W(CNT_W)) u_hold (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .load_in(any_src),
        .count_in(hold_cnt),
        .done_out(hold_done)
    );

    // ****************************************************************
    // oscillator start-up and pll lock, in parallel with hold
    // ****************************************************************
    logic [10:0] ost_ff;
    logic [CNT_W-1:0] lock_ff;
    logic [CNT_W-1:0] mon_ff;
    logic [CNT_W-1:0] wake_ff;
    wire ost_ok = !is_xtal || ost_ff == 11'(`RCS_OST_COUNT);
    wire lock_ok = !is_pll || (lock_ff == '0 && pll_locked_in);
    // counters restart on every reset source
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || any_src)
        begin
            ost_ff <= '0;
            lock_ff <= CNT_W'(LOCK_CYC);
        end
        else
        begin
            if (osc_tick_in && !ost_ok)
                ost_ff <= ost_ff + 11'h001;
            if (lock_ff != '0)
                lock_ff <= lock_ff - 1'b1;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    rcs_pkg::rcs_state_type st_ff;
    logic system_reset_ff;
    logic clkv_ff;
    logic run_ff;
    logic mon_on_ff;
    logic armed_ff; // a source has loaded the hold timer since rstn_in
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            st_ff <= rcs_pkg::ST_HOLD;
            system_reset_ff <= 1'b1;
            clkv_ff <= 1'b0;
            run_ff <= 1'b0;
            mon_on_ff <= 1'b0;
            mon_ff <= '0;
            wake_ff <= '0;
            armed_ff <= 1'b0;
        end
        else if (any_src)
        begin
            st_ff <= rcs_pkg::ST_HOLD;
            system_reset_ff <= 1'b1;
            clkv_ff <= 1'b0;
            run_ff <= 1'b0;
            mon_on_ff <= 1'b0;
            armed_ff <= 1'b1;
        end
        else
        begin
            clkv_ff <= ost_ok && lock_ok;
            case (st_ff)
                rcs_pkg::ST_HOLD:
                begin
                    // rstn_in alone never releases, a source must arm the hold
                    if (hold_done && armed_ff)
                    begin
                        system_reset_ff <= 1'b0;
                        mon_ff <= CNT_W'(CLOCK_FAIL_MONITOR_CYC);
                        st_ff <= rcs_pkg::ST_RUN;
                    end
                end
                rcs_pkg::ST_RUN:
                begin
                    run_ff <= ost_ok && lock_ok;
                    if (mon_ff != '0)
                        mon_ff <= mon_ff - 1'b1;
                    mon_on_ff <= (is_pll || is_xtal) && mon_ff == '0;
                    if (wake_in && regulator_en_in)
                    begin
                        run_ff <= 1'b0;
                        wake_ff <= CNT_W'(STARTUP_CYC);
                        st_ff <= rcs_pkg::ST_WAKE;
                    end
                end
                rcs_pkg::ST_WAKE:
                begin
                    if (wake_ff != '0)
                        wake_ff <= wake_ff - 1'b1;
                    else
                        st_ff <= rcs_pkg::ST_RUN;
                end
                default:
                    st_ff <= rcs_pkg::ST_HOLD;
            endcase
        end
    end

    // ****************************************************************
    // apb read and outputs
    // ****************************************************************
    logic [31:0] rd_ff;
    logic rdy_ff;
    logic err_ff;
    logic wdt_ff;
    logic vreg_ff;
    logic [2:0] oscout_ff;
    wire [31:0] rd_mux = hit_st ? {16'h0000, status_ff}
        : hit_cs ? {29'h0000_0000, osc_ff}
        : hit_tm ? {28'h0000_000, mon_on_ff, run_ff, clkv_ff, system_reset_ff} : 32'h0000_0000;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            rd_ff <= '0;
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            wdt_ff <= 1'b1;
            vreg_ff <= 1'b0;
            pin_d_ff <= 1'b0;
            oscout_ff <= '0;
        end
        else
        begin
            rdy_ff <= psel_in && !penable_in;
            err_ff <= psel_in && !penable_in && !hit;
            rd_ff <= rd_mux;
            wdt_ff <= watchdog_fuse_enable_in || status_ff[`RCS_B_SWDT];
            vreg_ff <= status_ff[`RCS_B_VREG];
            pin_d_ff <= pin_lvl;
            oscout_ff <= osc_ff;
        end
    end
    assign prdata_out = rd_ff;
    assign pready_out = rdy_ff;
    assign pslverr_out = err_ff;
    assign system_reset_out = system_reset_ff;
    assign clock_valid_out = clkv_ff;
    assign cpu_run_out = run_ff;
    assign monitor_active_out = mon_on_ff;
    assign watchdog_en_out = wdt_ff;
    assign regulator_sleep_keepalive_out = vreg_ff;
    assign reset_osc_select_out = oscout_ff;
endmodule : rcs_top

// file: sim/rcs_src_model.sv
// far side model: reset sources, crystal ticks and pll lock
`timescale 1ns/1ps
module rcs_src_model (
    input wire logic clk_sys_in,
    output rcs_pkg::rcs_src_type src_out,
    output logic osc_tick_out,
    output logic pll_locked_out
);
    logic [1:0] div_ff = 2'h0; // crystal runs at a quarter of the clock
    initial src_out = '0;
    initial pll_locked_out = 1'b0;
    // free running crystal divider
    always @(posedge clk_sys_in)
        div_ff <= div_ff + 2'h1;
    assign osc_tick_out = (div_ff == 2'h3);
    // pll locks some time after start
    initial
    begin
        repeat (100) @(posedge clk_sys_in);
        pll_locked_out <= 1'b1;
    end
    // one cycle pulse of the given sources
    task fire(input rcs_pkg::rcs_src_type s);
    begin
        @(posedge clk_sys_in);
        src_out <= s;
        @(posedge clk_sys_in);
        src_out <= '0;
    end
    endtask : fire
endmodule : rcs_src_model

// file: sim/rcs_top_asserts.sv
// checker of the reset cause and release block, bound to its top
`timescale 1ns/1ps
module rcs_top_asserts #(
    parameter int CLOCK_FAIL_MONITOR_CYC = 200
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire rcs_pkg::rcs_src_type src_in,
    input wire logic clk_switch_en_in,
    input wire logic watchdog_fuse_enable_in,
    input wire logic [2:0] config_oscillator_select_in,
    input wire logic [2:0] current_oscillator_select_in,
    input wire logic system_reset_out,
    input wire logic clock_valid_out,
    input wire logic cpu_run_out,
    input wire logic monitor_active_out,
    input wire logic watchdog_en_out,
    input wire logic regulator_sleep_keepalive_out,
    input wire logic [2:0] reset_osc_select_out
);
    localparam int CLOCK_FAIL_MONITOR_MIN = CLOCK_FAIL_MONITOR_CYC - 2; // slack for register stages
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    logic [15:0] since_src_ff; // cycles since the last source pulse
    // counter restarts on every source pulse, saturates at the top
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || (|src_in))
            since_src_ff <= 16'h0000;
        else if (since_src_ff != 16'hFFFF)
            since_src_ff <= since_src_ff + 16'h0001;
    end
    a_src_asserts_rst: assert property ((|src_in) |=> system_reset_out)
        else $error("source pulse did not assert system reset");
    a_por_clears_flags: assert property (
        src_in.por |=> ##1 (!regulator_sleep_keepalive_out
        && watchdog_en_out == $past(watchdog_fuse_enable_in)))
        else $error("power-on left a flag set");
    a_fuse_forces_wdt: assert property ($past(watchdog_fuse_enable_in) |-> watchdog_en_out)
        else $error("watchdog off while fuse set");
    a_min_hold_time: assert property ($fell(system_reset_out) |-> since_src_ff >= 16'h0F9C)
        else $error("system reset released too early");
    a_no_early_fetch: assert property ($rose(cpu_run_out) |->
        clock_valid_out && !system_reset_out)
        else $error("fetch started without clock or in reset");
    a_monitor_wait: assert property ($rose(monitor_active_out) |->
        $past(system_reset_out, CLOCK_FAIL_MONITOR_MIN) == 1'b0)
        else $error("monitor started too soon");
    a_sw_write_safe: assert property (
        !system_reset_out && src_in == '0 && psel_in
        && penable_in && pwrite_in |=> !system_reset_out)
        else $error("register write caused reset");
    // the chosen source reaches the pin two flops after the source pulse
    a_osc_fixed_cfg: assert property ((|src_in) && !clk_switch_en_in |-> ##2
        reset_osc_select_out == $past(config_oscillator_select_in, 2))
        else $error("clock source not from config");
    a_osc_keep_cur: assert property (clk_switch_en_in && (src_in.pin
        || src_in.instruction_reset_flag || src_in.wdt) && !src_in.por && !src_in.bor |-> ##2
        reset_osc_select_out == $past(current_oscillator_select_in, 2))
        else $error("clock source not kept");
    a_unmapped_err: assert property (psel_in && !penable_in && paddr_in >= 12'h00C |=>
        pready_out && pslverr_out)
        else $error("unmapped access not refused");
    c_release: cover property ($fell(system_reset_out));
    c_monitor: cover property ($rose(monitor_active_out));
    c_refused: cover property (pslverr_out);
endmodule : rcs_top_asserts
bind rcs_top rcs_top_asserts #(.CLOCK_FAIL_MONITOR_CYC(CLOCK_FAIL_MONITOR_CYC)) u_asserts (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .src_in(src_in), .clk_switch_en_in(clk_switch_en_in),
    .watchdog_fuse_enable_in(watchdog_fuse_enable_in),
    .config_oscillator_select_in(config_oscillator_select_in),
    .current_oscillator_select_in(current_oscillator_select_in),
    .system_reset_out(system_reset_out), .clock_valid_out(clock_valid_out),
    .cpu_run_out(cpu_run_out), .monitor_active_out(monitor_active_out),
    .watchdog_en_out(watchdog_en_out),
    .regulator_sleep_keepalive_out(regulator_sleep_keepalive_out),
    .reset_osc_select_out(reset_osc_select_out));

// file: sim/rcs_top_tb.sv
// self-checking bench of the reset cause and release block
`timescale 1ns/1ps
`include "rcs_defs.svh"
module rcs_top_tb;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, master_clear_pin_n = 1'b1, sleep = 1'b0, idle = 1'b0, reg_en = 1'b1, wake = 1'b0;
    logic sw_en = 1'b0, fuse = 1'b0, osc_tick, pll_lock, system_reset, cvalid, run, mon, wdt_en, keep;
    logic [2:0] cfg_osc = `RCS_OSC_SEC, cur_osc = `RCS_OSC_PRI, rst_osc;
    rcs_pkg::rcs_src_type src;
    int err_total = 0, checked = 0, n;
    always #2.5 clk = ~clk;
    rcs_top #(.POWER_UP_TIMER_CYC(1000), .CLOCK_FAIL_MONITOR_CYC(200)) DUT (
        .clk_sys_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .src_in(src),
        .master_clear_pin_n_in(master_clear_pin_n), .sleep_enter_in(sleep), .idle_enter_in(idle),
        .wake_in(wake), .osc_tick_in(osc_tick), .pll_locked_in(pll_lock),
        .regulator_en_in(reg_en), .clk_switch_en_in(sw_en),
        .watchdog_fuse_enable_in(fuse), .config_oscillator_select_in(cfg_osc),
        .current_oscillator_select_in(cur_osc), .system_reset_out(system_reset),
        .clock_valid_out(cvalid), .cpu_run_out(run), .monitor_active_out(mon),
        .watchdog_en_out(wdt_en), .regulator_sleep_keepalive_out(keep),
        .reset_osc_select_out(rst_osc));
    rcs_src_model u_src (.clk_sys_in(clk), .src_out(src), .osc_tick_out(osc_tick),
        .pll_locked_out(pll_lock));
    // compare of a value
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask : chk
    // compare of a hold length, a few cycles of slack
    task chk_near(input int got, input int exp);
    begin
        checked++;
        if (got < exp - 4 || got > exp + 4)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t hold %0d exp %0d", $time, got, exp);
        end
    end
    endtask : chk_near
    // one apb transfer, read data left in rd
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
    begin
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // pready looked at where settled, before the edge that ends the access
        do
        begin
            @(negedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        chk(k < 50, 1);
        rd = prdata;
        perr = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    end
    endtask : apb
    // counts cycles until system reset lets go
    task wait_rel;
    begin
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (system_reset !== 1'b0 && n < 30000);
    end
    endtask : wait_rel
    task t_power_on;
    begin
        u_src.fire(7'h40);
        repeat (1000) @(posedge clk);
        chk(cvalid, 0);
        wait_rel();
        chk_near(n + 1000, 10000);
        apb(0, `RCS_OFF_STATUS, 0);
        chk(rd, 32'h0000_0003);
        chk(rst_osc, cfg_osc);
        repeat (210) @(posedge clk);
        chk({cvalid, run, mon}, 3'h7);
        $display("test power_on done");
    end
    endtask : t_power_on
    task t_soft_write;
    begin
        apb(1, `RCS_OFF_STATUS, 32'h0000_FFFF);
        apb(0, `RCS_OFF_STATUS, 0);
        chk(rd, 32'h0000_C1FF);
        chk({system_reset, keep, wdt_en}, 3'h3);
        apb(1, `RCS_OFF_STATUS, 0);
        repeat (2) @(posedge clk);
        chk({keep, wdt_en}, 2'h0);
        fuse <= 1'b1;
        repeat (2) @(posedge clk);
        chk(wdt_en, 1);
        fuse <= 1'b0;
        apb(0, 12'h010, 0);
        chk(perr, 1);
        chk(rd, 32'h0000_0000);
        $display("test soft_write done");
    end
    endtask : t_soft_write
    task t_causes;
        logic [6:0] s [6] = '{7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h03};
        logic [15:0] e [6] = '{16'h0080, 16'h0040, 16'h0010, 16'h8000, 16'h4000, 16'hC000};
    begin
        sw_en <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1, `RCS_OFF_STATUS, 0);
            u_src.fire(s[i]);
            wait_rel();
            chk_near(n, 4000);
            apb(0, `RCS_OFF_STATUS, 0);
            chk(rd, {16'h0000, e[i]});
            if (i < 3)
                chk(rst_osc, cur_osc);
        end
        apb(1, `RCS_OFF_STATUS, 0);
        master_clear_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        master_clear_pin_n <= 1'b1;
        chk(system_reset, 1);
        wait_rel();
        apb(0, `RCS_OFF_STATUS, 0);
        chk(rd, 32'h0000_0080);
        $display("test causes done");
    end
    endtask : t_causes
    task t_brownout;
    begin
        reg_en <= 1'b0;
        apb(1, `RCS_OFF_STATUS, 32'h0000_C1FF);
        u_src.fire(7'h20);
        wait_rel();
        chk_near(n, 5000);
        apb(0, `RCS_OFF_STATUS, 0);
        chk(rd & 32'h0000_C0DF, 32'h0000_0083);
        chk(rst_osc, cfg_osc);
        reg_en <= 1'b1;
        $display("test brownout done");
    end
    endtask : t_brownout
    task t_power_save;
    begin
        apb(1, `RCS_OFF_STATUS, 32'h0000_0010);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        apb(0, `RCS_OFF_STATUS, 0);
        chk(rd, 32'h0000_0008);
        idle <= 1'b1;
        @(posedge clk);
        idle <= 1'b0;
        apb(0, `RCS_OFF_STATUS, 0);
        chk(rd, 32'h0000_000C);
        // wake with the regulator on stalls fetch for the start-up delay
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(posedge clk);
        #1;
        chk(run, 0);
        n = 0;
        while (run !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_near(n, 4000);
        $display("test power_save done");
    end
    endtask : t_power_save
    // prints counts and the verdict, ends the run
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : stop_test
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_power_on();
        t_soft_write();
        t_causes();
        t_brownout();
        t_power_save();
        stop_test();
    end
    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge clk); // planned run is under 50000 cycles
        err_total++;
        stop_test();
    end
endmodule : rcs_top_tb
